// File: common/sramc_pkg.sv
// Constants, state encoding and timing counts for the asynchronous byte-wide memory controller.
package sramc_pkg;

	localparam int SRAMC_ADDR_W = 15;
	localparam int SRAMC_DATA_W = 8;
	localparam int SRAMC_CLK_NS = 4;

	// Slow-grade figures, which also satisfy the fast grade.
	localparam int SRAMC_ACCESS_NS = 70;
	localparam int SRAMC_WINDOW_NS = 50;
	localparam int SRAMC_READ_CYCLE_NS = 70;
	localparam int SRAMC_OE_OFF_NS = 30;

	// Least times round up to whole cycles.
	localparam int SRAMC_ACCESS_CYC = (SRAMC_ACCESS_NS + SRAMC_CLK_NS - 1) / SRAMC_CLK_NS;
	localparam int SRAMC_WINDOW_CYC = (SRAMC_WINDOW_NS + SRAMC_CLK_NS - 1) / SRAMC_CLK_NS;
	localparam int SRAMC_RECOVER_CYC = (SRAMC_READ_CYCLE_NS + SRAMC_CLK_NS - 1) / SRAMC_CLK_NS;
	localparam int SRAMC_TURN_CYC = (SRAMC_OE_OFF_NS + SRAMC_CLK_NS - 1) / SRAMC_CLK_NS;

	localparam int SRAMC_CNT_W = 6;

	typedef enum logic [2:0] {
		SRAMC_IDLE = 3'b000,
		SRAMC_READ = 3'b001,
		SRAMC_WRITE = 3'b010,
		SRAMC_TURN = 3'b011,
		SRAMC_RETAIN = 3'b100,
		SRAMC_RECOVER = 3'b101
	} sramc_state_e;

endpackage

// File: hw/sramc_host.sv
// Host-side controller that runs read and write cycles on the asynchronous byte-wide memory.
module sramc_host (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [sramc_pkg::SRAMC_ADDR_W-1:0] req_addr,
	input wire logic [sramc_pkg::SRAMC_DATA_W-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [sramc_pkg::SRAMC_DATA_W-1:0] rsp_rdata,
	input wire logic retain_req,
	output logic retain_ack,
	output logic [sramc_pkg::SRAMC_ADDR_W-1:0] address_bus,
	input wire logic [sramc_pkg::SRAMC_DATA_W-1:0] data_bus_i,
	output logic [sramc_pkg::SRAMC_DATA_W-1:0] data_bus_o,
	output logic data_bus_oe,
	output logic chip_sel_n,
	output logic out_en_n,
	output logic wr_strobe_n
);
	import sramc_pkg::*;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	sramc_state_e state_q, state_d;
	logic [SRAMC_CNT_W-1:0] cnt_q, cnt_d;
	logic [SRAMC_ADDR_W-1:0] addr_q, addr_d;
	logic [SRAMC_DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic rsp_q, rsp_d;
	logic cs_n_q, cs_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, drv_q, drv_d;

	function automatic logic [SRAMC_CNT_W-1:0] cyc(input int n);
		cyc = SRAMC_CNT_W'(n - 1);
	endfunction

	assign req_ready = (state_q == SRAMC_IDLE) && !retain_req;
	assign retain_ack = (state_q == SRAMC_RETAIN);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		rsp_d = 1'b0;
		cs_n_d = cs_n_q;
		oe_n_d = oe_n_q;
		we_n_d = we_n_q;
		drv_d = drv_q;
		case (state_q)
			SRAMC_IDLE: begin
				cs_n_d = 1'b1;
				oe_n_d = 1'b1;
				we_n_d = 1'b1;
				drv_d = 1'b0;
				if (retain_req) begin
					state_d = SRAMC_RETAIN;
				end else if (req_valid) begin
					addr_d = req_addr;
					wdata_d = req_wdata;
					cs_n_d = 1'b0;
					if (req_write) begin
						// OE held high over the write
						// write decoded by CS and WE low
						we_n_d = 1'b0;
						drv_d = 1'b1;
						cnt_d = cyc(SRAMC_WINDOW_CYC);
						state_d = SRAMC_WRITE;
					end else begin
						oe_n_d = 1'b0;
						cnt_d = cyc(SRAMC_ACCESS_CYC);
						state_d = SRAMC_READ;
					end
				end
			end
			SRAMC_READ: begin
				// sample only after the access time
				if (cnt_q == '0) begin
					rdata_d = data_bus_i;
					rsp_d = 1'b1;
					cs_n_d = 1'b1;
					oe_n_d = 1'b1;
					cnt_d = cyc(SRAMC_TURN_CYC);
					state_d = SRAMC_TURN;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			SRAMC_WRITE: begin
				// strobe low for the full window
				if (cnt_q == '0) begin
					cs_n_d = 1'b1;
					we_n_d = 1'b1;
					// The memory needs no data hold past the strobe, so the pins are freed with it.
					// Keeping them driven longer would only widen the window for a clash on the bus.
					drv_d = 1'b0;
					state_d = SRAMC_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			SRAMC_TURN: begin
				// wait for memory outputs to float
				if (cnt_q == '0) begin
					state_d = SRAMC_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			SRAMC_RETAIN: begin
				if (!retain_req) begin
					cnt_d = cyc(SRAMC_RECOVER_CYC);
					state_d = SRAMC_RECOVER;
				end
			end
			SRAMC_RECOVER: begin
				if (cnt_q == '0) begin
					state_d = SRAMC_IDLE;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			default: begin
				state_d = SRAMC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= SRAMC_IDLE;
			cnt_q <= '0;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			rsp_q <= 1'b0;
			cs_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			drv_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			rsp_q <= rsp_d;
			cs_n_q <= cs_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			drv_q <= drv_d;
		end
	end

	// fifteen address bits reach the memory
	assign address_bus = addr_q;
	// shared data pins driven only on writes
	assign data_bus_o = wdata_q;
	assign data_bus_oe = drv_q;
	assign chip_sel_n = cs_n_q;
	assign out_en_n = oe_n_q;
	assign wr_strobe_n = we_n_q;
	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_read_we_high: assert property (state_q == SRAMC_READ |-> wr_strobe_n && !chip_sel_n)
		else $error("Write strobe low during read.");
	a_no_contention: assert property (data_bus_oe |-> out_en_n && !wr_strobe_n)
		else $error("Host drives data while memory may drive.");
	// The window is counted in whole cycles of both controls low, so the first of them to rise ends it.
	a_write_window: assert property ($fell(wr_strobe_n) |-> (!wr_strobe_n && !chip_sel_n)[*8] ##1
		(!wr_strobe_n && !chip_sel_n)[*5])
		else $error("Write window shorter than needed.");
	a_write_data_hold: assert property (!wr_strobe_n && !$fell(wr_strobe_n) |-> data_bus_oe && $stable(data_bus_o))
		else $error("Write data moved inside the window.");
	a_write_release: assert property ($rose(wr_strobe_n) |-> chip_sel_n && !data_bus_oe)
		else $error("Data pins still driven after the write.");
	a_write_oe_stable: assert property (!wr_strobe_n |-> out_en_n && $stable(out_en_n))
		else $error("Output enable moved in write.");
	a_read_latency: assert property ($fell(out_en_n) |-> ##18 rsp_valid)
		else $error("Read data not sampled at access time.");
	a_access_addr_hold: assert property (!chip_sel_n && !$fell(chip_sel_n) |-> $stable(address_bus))
		else $error("Address moved during an access.");
	a_read_decode: assert property (state_q == SRAMC_READ |-> !out_en_n && !data_bus_oe)
		else $error("Read not decoded on the control pins.");
	// ****************************************************************
	// Retention, turnaround and idle checks
	// ****************************************************************
	// A parked chip must see no stray strobes, or a brown-out could corrupt a byte.
	a_retain_cs_high: assert property (retain_ack |-> chip_sel_n)
		else $error("Chip selected during retention.");
	a_retain_quiet: assert property (retain_ack |-> out_en_n && wr_strobe_n && !data_bus_oe)
		else $error("Controls active during retention.");
	a_recover_hold: assert property ($fell(retain_ack) |-> chip_sel_n[*8] ##1 chip_sel_n[*8] ##1
		chip_sel_n[*2])
		else $error("Chip selected too soon after retention.");
	a_turnaround: assert property (rsp_valid |-> (!req_ready)[*8])
		else $error("New access before outputs float.");
	a_idle_deselect: assert property (state_q == SRAMC_IDLE |-> chip_sel_n)
		else $error("Chip left selected while idle.");

	c_read: cover property ($fell(out_en_n) ##[1:40] rsp_valid);
	c_write: cover property ($fell(wr_strobe_n) ##[1:40] $rose(wr_strobe_n));
	c_retain: cover property ($rose(retain_ack) ##[1:200] $fell(retain_ack));
	c_back_to_back: cover property (rsp_valid ##[1:40] $fell(wr_strobe_n));
	c_write_pair: cover property ($rose(wr_strobe_n) ##[1:40] $fell(wr_strobe_n));

endmodule

// File: dv/sramc_mem_model.sv
// Behavioural model of the byte-wide static memory seen by the controller.
module sramc_mem_model (
	input wire logic [14:0] address_bus,
	input wire logic [7:0] data_bus_o,
	input wire logic data_bus_oe,
	input wire logic chip_sel_n,
	input wire logic out_en_n,
	input wire logic wr_strobe_n,
	output logic [7:0] data_bus_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:32767];
	logic [7:0] last_q = 8'h00;
	logic [7:0] wd_q;
	logic [14:0] wa_q;
	logic open_q = 1'b0;
	logic drive;
	assign drive = !chip_sel_n && !out_en_n && wr_strobe_n;
	// shared wire
	// A released wire shows the inverse of its last value, so a stale byte never passes.
	assign data_bus_i = data_bus_oe ? data_bus_o : (drive ? mem[address_bus] : ~last_q);
	always @* if (data_bus_oe || drive) last_q = data_bus_i;
	// write window
	// Only a byte the host really drives is latched, so freeing the pins as the strobe rises cannot spoil it.
	always @* begin
		if (!chip_sel_n && !wr_strobe_n) begin
			wa_q = address_bus;
			if (data_bus_oe) wd_q = data_bus_o;
			open_q = 1'b1;
		end else if (open_q) begin
			mem[wa_q] = wd_q;
			open_q = 1'b0;
		end
	end
endmodule

// File: dv/sramc_host_tb.sv
// Self-checking bench for the memory controller.
module sramc_host_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, retain_req = 0;
	logic [14:0] req_addr = 15'h0000, address_bus;
	logic [7:0] req_wdata = 8'h00, rsp_rdata, data_bus_i, data_bus_o;
	logic req_ready, rsp_valid, retain_ack, data_bus_oe, chip_sel_n, out_en_n, wr_strobe_n;
	int bad_count = 0, n_checks = 0, i, n;
	initial forever #2 sys_clk = ~sys_clk;
	sramc_host u_dut (.sys_clk, .sys_rst, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
		.rsp_valid, .rsp_rdata, .retain_req, .retain_ack, .address_bus, .data_bus_i, .data_bus_o,
		.data_bus_oe, .chip_sel_n, .out_en_n, .wr_strobe_n);
	sramc_mem_model u_mem (.address_bus, .data_bus_o, .data_bus_oe, .chip_sel_n, .out_en_n,
		.wr_strobe_n, .data_bus_i);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		i = 0;
		@(negedge sys_clk);
		while (req_ready !== 1'b1 && i < 100) begin
			i++;
			@(negedge sys_clk);
		end
		if (i == 100) begin
			bad_count++;
			print_verdict();
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		req(1'b1, a, d);
		n = 0;
		i = 0;
		repeat (16) begin
			@(negedge sys_clk);
			n += !chip_sel_n && !wr_strobe_n;
			i += !out_en_n;
		end
		chk("write window", 16'h000D, 16'(n));
		chk("enable in write", 16'h0000, 16'(i));
		$display("write test done");
	endtask
	task automatic rd(input logic [14:0] a, input logic [7:0] e);
		req(1'b0, a, 8'h00);
		n = 0;
		@(negedge sys_clk);
		while (rsp_valid !== 1'b1 && n < 40) begin
			chk("strobe in read", 16'h0001, {15'h0000, wr_strobe_n});
			n++;
			@(negedge sys_clk);
		end
		chk("read latency", 16'h0012, 16'(n));
		if (n == 40) print_verdict();
		chk("read data", {8'h00, e}, {8'h00, rsp_rdata});
		$display("read test done");
	endtask
	task automatic ret();
		@(posedge sys_clk) retain_req <= 1'b1;
		n = 0;
		@(negedge sys_clk);
		while (retain_ack !== 1'b1 && n < 40) begin
			n++;
			@(negedge sys_clk);
		end
		chk("parked ack", 16'h0001, {15'h0000, retain_ack});
		chk("parked select", 16'h0001, {15'h0000, chip_sel_n});
		chk("parked ready", 16'h0000, {15'h0000, req_ready});
		@(posedge sys_clk) retain_req <= 1'b0;
		n = 0;
		while (req_ready !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			chk("select after park", 16'h0001, {15'h0000, chip_sel_n});
			n++;
		end
		chk("recovery", 16'h0001, {15'h0000, n >= 18});
		if (n == 40) print_verdict();
		$display("retention test done");
	endtask
	always @(negedge sys_clk) if (!sys_rst) chk("contention", 16'h0000, {15'h0000, data_bus_oe & u_mem.drive});
	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wr(15'h0000, 8'hA5);
		wr(15'h7FFF, 8'h3C);
		rd(15'h7FFF, 8'h3C);
		rd(15'h0000, 8'hA5);
		ret();
		rd(15'h7FFF, 8'h3C);
		wr(15'h1234, 8'h5A);
		rd(15'h1234, 8'h5A);
		print_verdict();
	end
endmodule
